// >>> src/ils_scoreboard.v
// Issue latency scoreboard: holds dependent and unit-conflicting instructions
// What this block does
// - Dependent instruction waits until producer latency elapsed since producer issue.
// - Same-unit independent instructions spaced by at least the repeat rate.
// - Integer-to-float word move: latency 1, one per cycle.
// - Float-to-integer move: latency 1, one per cycle.
// - Fused multiply-add forms: long float pipe, latency 8, rate 1.
// - Sign injection forms: short float pipe, latency 1, rate 1.
// - Double square root: long pipe, 23 to 24 cycles, unpipelined.
// - Single square root: long pipe, 14 to 22 cycles, unpipelined.
// - Float subtract: long pipe, latency 4, rate 1.
// - Integer loads: load/store unit, latency 4, one per cycle.
// - Integer stores: no result, one per cycle on load/store unit.
// - Float stores: no result latency, one per cycle.
// - Full multiplies: multiplier unit, latency 4, rate 1.
// - Word multiply: latency 3, rate 1.
// - Remainder: divider, 7 to 22 cycles, unpipelined.
// - Simple integer ops: latency 1, rate 1, two ALUs.
// - Mode returns and wait-for-interrupt: decode/graduation unit, latency 3.
// - Jump and link forms: control-transfer unit, latency 1, rate 1.
`timescale 1ns/1ps
`include "ils_regs.vh"
module ils_scoreboard #(
  parameter NREG = 64,
  parameter RW = 6
) (
  input wire clk_sys,
  input wire reset,
  input wire dec_valid,
  input wire [`ILS_CL_W-1:0] dec_class,
  input wire dec_src1_en,
  input wire [RW-1:0] dec_src1,
  input wire dec_src2_en,
  input wire [RW-1:0] dec_src2,
  input wire dec_src3_en,
  input wire [RW-1:0] dec_src3,
  input wire dec_dst_en,
  input wire [RW-1:0] dec_dst,
  input wire div_done,
  input wire sqrt_done,
  output reg issue_r,
  output reg [`ILS_UNIT_W-1:0] issue_unit_r,
  output reg issue_alu_sel_r,
  output reg stall_r,
  output reg div_busy_r,
  output reg sqrt_busy_r
);
  wire [`ILS_UNIT_W-1:0] unit;
  wire [`ILS_LAT_W-1:0] lat;
  wire [`ILS_LAT_W-1:0] rate;
  wire var_lat;
  wire has_dst;
  wire [NREG-1:0] reg_busy;
  // Per-unit repeat countdown; index by unit code
  reg [`ILS_LAT_W-1:0] unit_cnt_r [0:7];
  reg alu_last_r;
  reg [`ILS_UNIT_W-1:0] unit_d;
  reg dep_hit;
  reg unit_hit;
  reg go;
  reg wr_dst;
  reg is_div;
  reg is_sqrt;
  integer k;
  // Which variable unit owns each pending register (1 = divider)
  reg [NREG-1:0] dq_r;

  ils_class_decode u_dec (
    .cls(dec_class),
    .unit(unit),
    .lat(lat),
    .rate(rate),
    .var_lat(var_lat),
    .has_dst(has_dst)
  );

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      wire ld;
      wire dn;
      assign ld = go && wr_dst && (dec_dst == g);
      // Completion frees only registers owned by that variable unit
      assign dn = (div_done && (dq_r[g] == 1'b1)) || (sqrt_done && (dq_r[g] == 1'b0));
      ils_reg_timer u_tmr (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(ld),
        .lat(lat),
        .var_lat(var_lat),
        .done(dn),
        .busy(reg_busy[g])
      );
    end
  endgenerate

  always @* begin
    is_div = (unit == `ILS_U_DIV);
    is_sqrt = var_lat && (unit == `ILS_U_FLONG);
    wr_dst = has_dst && dec_dst_en && (dec_dst != {RW{1'b0}});
    // Dependence check on sources and on the destination itself
    dep_hit = (dec_src1_en && reg_busy[dec_src1]) ||
              (dec_src2_en && reg_busy[dec_src2]) ||
              (dec_src3_en && reg_busy[dec_src3]) ||
              (wr_dst && reg_busy[dec_dst]);
    unit_d = unit;
    unit_hit = (unit_cnt_r[unit] > `ILS_LAT_1);
    if (is_div && div_busy_r)
      unit_hit = 1'b1;
    if ((unit == `ILS_U_FLONG) && sqrt_busy_r)
      unit_hit = 1'b1;
    if (is_sqrt && (unit_cnt_r[`ILS_U_FLONG] != `ILS_LAT_0))
      unit_hit = 1'b1;
    go = dec_valid && !dep_hit && !unit_hit;
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      for (k = 0; k < 8; k = k + 1)
        unit_cnt_r[k] <= `ILS_LAT_0;
      alu_last_r <= 1'b0;
      dq_r <= {NREG{1'b0}};
      issue_r <= 1'b0;
      issue_unit_r <= `ILS_U_ALU;
      issue_alu_sel_r <= 1'b0;
      stall_r <= 1'b0;
      div_busy_r <= 1'b0;
      sqrt_busy_r <= 1'b0;
    end else begin
      for (k = 0; k < 8; k = k + 1)
        if (unit_cnt_r[k] != `ILS_LAT_0)
          unit_cnt_r[k] <= unit_cnt_r[k] - `ILS_LAT_1;
      // ALU pair alternates; with rate 1 both are free every cycle
      if (go && (unit == `ILS_U_ALU)) begin
        alu_last_r <= ~alu_last_r;
      end else if (go) begin
        unit_cnt_r[unit_d] <= rate;
      end
      if (go && wr_dst)
        dq_r[dec_dst] <= is_div;
      // Done wins only when no new op issues to that same unit in the same cycle
      if (go && is_div)
        div_busy_r <= 1'b1;
      else if (div_done)
        div_busy_r <= 1'b0;
      if (go && is_sqrt)
        sqrt_busy_r <= 1'b1;
      else if (sqrt_done)
        sqrt_busy_r <= 1'b0;
      issue_r <= go;
      issue_unit_r <= unit;
      issue_alu_sel_r <= alu_last_r;
      stall_r <= dec_valid && !go;
    end
  end
endmodule

// >>> src/ils_regs.vh
// Latency, repeat and class constants for the issue latency scoreboard
`ifndef ILS_REGS_VH
`define ILS_REGS_VH
// Clock rate of the core clock in MHz
`define ILS_CLK_MHZ 10
// Instruction class codes presented by decode
`define ILS_CL_W 5
`define ILS_CL_ALU 5'h00
`define ILS_CL_JAL 5'h01
`define ILS_CL_LOAD 5'h02
`define ILS_CL_STORE 5'h03
`define ILS_CL_FSTORE 5'h04
`define ILS_CL_MUL 5'h05
`define ILS_CL_MULW 5'h06
`define ILS_CL_REM 5'h07
`define ILS_CL_FMA 5'h08
`define ILS_CL_FSUB 5'h09
`define ILS_CL_FSGNJ 5'h0A
`define ILS_CL_FSQRTD 5'h0B
`define ILS_CL_FSQRTS 5'h0C
`define ILS_CL_MVXF 5'h0D
`define ILS_CL_MVFX 5'h0E
`define ILS_CL_XRET 5'h0F
// Unit codes
`define ILS_UNIT_W 3
`define ILS_U_ALU 3'h0
`define ILS_U_CTU 3'h1
`define ILS_U_LSU 3'h2
`define ILS_U_MUL 3'h3
`define ILS_U_DIV 3'h4
`define ILS_U_FLONG 3'h5
`define ILS_U_FSHORT 3'h6
`define ILS_U_DGU 3'h7
// Latencies and repeat rates in cycles
`define ILS_LAT_W 4
`define ILS_LAT_0 4'h0
`define ILS_LAT_1 4'h1
`define ILS_LAT_3 4'h3
`define ILS_LAT_4 4'h4
`define ILS_LAT_8 4'h8
`define ILS_RATE_1 4'h1
// Variable-latency bounds, for reference by the execution units
`define ILS_REM_MIN 7
`define ILS_REM_MAX 22
`define ILS_SQRTD_MIN 23
`define ILS_SQRTD_MAX 24
`define ILS_SQRTS_MIN 14
`define ILS_SQRTS_MAX 22
`endif

// >>> src/ils_class_decode.v
// Maps an instruction class to its unit, latency, repeat rate and variable flag
`timescale 1ns/1ps
`include "ils_regs.vh"
module ils_class_decode (
  input wire [`ILS_CL_W-1:0] cls,
  output reg [`ILS_UNIT_W-1:0] unit,
  output reg [`ILS_LAT_W-1:0] lat,
  output reg [`ILS_LAT_W-1:0] rate,
  output reg var_lat,
  output reg has_dst
);
  always @* begin
    unit = `ILS_U_ALU;
    lat = `ILS_LAT_1;
    rate = `ILS_RATE_1;
    var_lat = 1'b0;
    has_dst = 1'b1;
    case (cls)
      `ILS_CL_ALU: unit = `ILS_U_ALU;
      `ILS_CL_JAL: unit = `ILS_U_CTU;
      `ILS_CL_LOAD: begin
        unit = `ILS_U_LSU;
        lat = `ILS_LAT_4;
      end
      `ILS_CL_STORE: begin
        unit = `ILS_U_LSU;
        lat = `ILS_LAT_0;
        has_dst = 1'b0;
      end
      `ILS_CL_FSTORE: begin
        unit = `ILS_U_LSU;
        lat = `ILS_LAT_0;
        has_dst = 1'b0;
      end
      `ILS_CL_MUL: begin
        unit = `ILS_U_MUL;
        lat = `ILS_LAT_4;
      end
      `ILS_CL_MULW: begin
        unit = `ILS_U_MUL;
        lat = `ILS_LAT_3;
      end
      `ILS_CL_REM: begin
        unit = `ILS_U_DIV;
        lat = `ILS_LAT_0;
        rate = `ILS_LAT_0;
        var_lat = 1'b1;
      end
      `ILS_CL_FMA: begin
        unit = `ILS_U_FLONG;
        lat = `ILS_LAT_8;
      end
      `ILS_CL_FSUB: begin
        unit = `ILS_U_FLONG;
        lat = `ILS_LAT_4;
      end
      `ILS_CL_FSGNJ: unit = `ILS_U_FSHORT;
      `ILS_CL_FSQRTD, `ILS_CL_FSQRTS: begin
        unit = `ILS_U_FLONG;
        lat = `ILS_LAT_0;
        rate = `ILS_LAT_0;
        var_lat = 1'b1;
      end
      `ILS_CL_MVXF: unit = `ILS_U_FLONG;
      `ILS_CL_MVFX: unit = `ILS_U_FSHORT;
      `ILS_CL_XRET: begin
        unit = `ILS_U_DGU;
        lat = `ILS_LAT_3;
        rate = `ILS_LAT_0;
        var_lat = 1'b0;
      end
      default: unit = `ILS_U_ALU;
    endcase
  end
endmodule

// >>> src/ils_reg_timer.v
// Per-register result-ready countdown with a pending flag for variable latency
`timescale 1ns/1ps
`include "ils_regs.vh"
module ils_reg_timer (
  input wire clk_sys,
  input wire reset,
  input wire load,
  input wire [`ILS_LAT_W-1:0] lat,
  input wire var_lat,
  input wire done,
  output wire busy
);
  reg [`ILS_LAT_W-1:0] cnt_r;
  reg pend_r;
  assign busy = (cnt_r > `ILS_LAT_1) || pend_r;
  always @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= `ILS_LAT_0;
      pend_r <= 1'b0;
    end else if (load) begin
      cnt_r <= lat;
      pend_r <= var_lat;
    end else begin
      if (cnt_r != `ILS_LAT_0)
        cnt_r <= cnt_r - `ILS_LAT_1;
      if (done)
        pend_r <= 1'b0;
    end
  end
endmodule

// >>> testbench/ils_sva.sv
// Concurrent checks on the issue latency scoreboard ports
`timescale 1ns/1ps
`include "ils_regs.vh"
module ils_sva (
  input wire clk_sys,
  input wire reset,
  input wire dec_valid,
  input wire [`ILS_CL_W-1:0] dec_class,
  input wire div_done,
  input wire sqrt_done,
  input wire issue_r,
  input wire [`ILS_UNIT_W-1:0] issue_unit_r,
  input wire issue_alu_sel_r,
  input wire stall_r,
  input wire div_busy_r,
  input wire sqrt_busy_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_issue_stall_excl: assert property (!(issue_r && stall_r))
    else $error("issue and stall together");
  chk_answer_has_cause: assert property (
    (issue_r || stall_r) |-> $past(dec_valid))
    else $error("answer without a presented instruction");
  chk_valid_answered: assert property (dec_valid |=> (issue_r ^ stall_r))
    else $error("presented instruction not answered");
  chk_mul_unit_code: assert property (
    (issue_r && $past(dec_class) == `ILS_CL_MUL) |-> issue_unit_r == `ILS_U_MUL)
    else $error("multiply not sent to multiplier unit");
  chk_div_busy_hold: assert property (
    (div_busy_r && !div_done) |=> div_busy_r)
    else $error("divider released before done");
  chk_div_unpiped: assert property (
    (div_busy_r && !div_done && dec_valid && dec_class == `ILS_CL_REM) |=> stall_r)
    else $error("remainder issued to busy divider");
  chk_sqrt_blocks_long: assert property (
    (sqrt_busy_r && !sqrt_done && dec_valid && dec_class == `ILS_CL_FMA) |=> stall_r)
    else $error("long pipe op issued during square root");
  chk_alu_alternate: assert property (
    (issue_r && issue_unit_r == `ILS_U_ALU) ##1 (issue_r && issue_unit_r == `ILS_U_ALU)
    |-> issue_alu_sel_r != $past(issue_alu_sel_r))
    else $error("back to back ALU issues on one ALU");
endmodule
bind ils_scoreboard ils_sva chk_u (.clk_sys(clk_sys), .reset(reset), .dec_valid(dec_valid),
  .dec_class(dec_class), .div_done(div_done), .sqrt_done(sqrt_done), .issue_r(issue_r),
  .issue_unit_r(issue_unit_r), .issue_alu_sel_r(issue_alu_sel_r), .stall_r(stall_r),
  .div_busy_r(div_busy_r), .sqrt_busy_r(sqrt_busy_r));

// >>> testbench/ils_exec_model.sv
// Divider and square-root units answering with one-cycle done pulses
`timescale 1ns/1ps
module ils_exec_model #(
  parameter DIV_LAT = 5'h09
) (
  input wire clk_sys,
  input wire reset,
  input wire div_busy_r,
  input wire sqrt_busy_r,
  input wire [4:0] sqrt_lat,
  output wire div_done,
  output wire sqrt_done
);
  reg [4:0] div_cnt_r;
  reg [4:0] sqrt_cnt_r;
  // Cycles spent busy since the unit took its operation
  always @(posedge clk_sys) begin
    div_cnt_r <= (reset || !div_busy_r) ? 5'h00 : div_cnt_r + 5'h01;
    sqrt_cnt_r <= (reset || !sqrt_busy_r) ? 5'h00 : sqrt_cnt_r + 5'h01;
  end
  assign div_done = div_busy_r && div_cnt_r == DIV_LAT;
  assign sqrt_done = sqrt_busy_r && sqrt_cnt_r == sqrt_lat;
endmodule

// >>> testbench/tb.sv
// Testbench for the issue latency scoreboard
`timescale 1ns/1ps
`include "ils_regs.vh"
module tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic dec_valid = 1'b0;
  logic [4:0] dec_class = 5'h00;
  logic s1_en = 1'b0;
  logic [5:0] s1 = 6'h00;
  logic d_en = 1'b0;
  logic [5:0] d = 6'h00;
  logic [4:0] sq_lat = 5'h16;
  wire div_done, sqrt_done, issue_r, issue_alu_sel_r, stall_r, div_busy_r, sqrt_busy_r;
  wire [2:0] issue_unit_r;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  ils_scoreboard dut_u (.clk_sys(clk_sys), .reset(reset), .dec_valid(dec_valid),
    .dec_class(dec_class), .dec_src1_en(s1_en), .dec_src1(s1), .dec_src2_en(1'b0),
    .dec_src2(6'h00), .dec_src3_en(1'b0), .dec_src3(6'h00), .dec_dst_en(d_en), .dec_dst(d),
    .div_done(div_done), .sqrt_done(sqrt_done), .issue_r(issue_r), .issue_unit_r(issue_unit_r),
    .issue_alu_sel_r(issue_alu_sel_r), .stall_r(stall_r), .div_busy_r(div_busy_r),
    .sqrt_busy_r(sqrt_busy_r));
  ils_exec_model part_u (.clk_sys(clk_sys), .reset(reset), .div_busy_r(div_busy_r),
    .sqrt_busy_r(sqrt_busy_r), .sqrt_lat(sq_lat), .div_done(div_done), .sqrt_done(sqrt_done));
  task final_report;
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report;
    end
  end
  task drv(input logic v, input logic [4:0] c, input logic [5:0] s, input logic [5:0] t);
    dec_valid <= v;
    dec_class <= c;
    s1_en <= (s != 6'h00);
    s1 <= s;
    d_en <= (t != 6'h00);
    d <= t;
  endtask
  task chk(input logic exp);
    checks_done++;
    if (issue_r !== exp) begin
      error_cnt++;
      $display("CHECK FAILED issue_r class %h expected %b seen %b", dec_class, exp, issue_r);
    end
    if (stall_r !== ~exp) begin
      error_cnt++;
      $display("CHECK FAILED stall_r class %h expected %b seen %b", dec_class, ~exp, stall_r);
    end
  endtask
  // Producer writes r5, consumer taken k cycles after the producer's issue
  task pair(input logic [4:0] pc, input logic [4:0] cc, input logic dep, input int k,
            input logic exp);
    @(posedge clk_sys);
    drv(1'b1, pc, 6'h00, 6'h05);
    for (int i = 1; i <= k + 2; i++) begin
      @(posedge clk_sys);
      if (i == 2) chk(1'b1);
      if (i == k + 2) chk(exp);
      else drv(i == k, cc, dep ? 6'h05 : 6'h00, 6'h00);
    end
    repeat (30) @(posedge clk_sys);
  endtask
  task fixed_lat;
    pair(`ILS_CL_MUL, `ILS_CL_ALU, 1, 3, 0);
    pair(`ILS_CL_MUL, `ILS_CL_ALU, 1, 4, 1);
    pair(`ILS_CL_MULW, `ILS_CL_ALU, 1, 2, 0);
    pair(`ILS_CL_MULW, `ILS_CL_ALU, 1, 3, 1);
    pair(`ILS_CL_LOAD, `ILS_CL_ALU, 1, 3, 0);
    pair(`ILS_CL_LOAD, `ILS_CL_ALU, 1, 4, 1);
    pair(`ILS_CL_FMA, `ILS_CL_ALU, 1, 7, 0);
    pair(`ILS_CL_FMA, `ILS_CL_ALU, 1, 8, 1);
    pair(`ILS_CL_FSUB, `ILS_CL_ALU, 1, 3, 0);
    pair(`ILS_CL_FSUB, `ILS_CL_ALU, 1, 4, 1);
    pair(`ILS_CL_ALU, `ILS_CL_ALU, 1, 1, 1);
    pair(`ILS_CL_FSGNJ, `ILS_CL_ALU, 1, 1, 1);
    pair(`ILS_CL_MVXF, `ILS_CL_ALU, 1, 1, 1);
    pair(`ILS_CL_MVFX, `ILS_CL_ALU, 1, 1, 1);
    pair(`ILS_CL_JAL, `ILS_CL_ALU, 1, 1, 1);
    pair(`ILS_CL_XRET, `ILS_CL_ALU, 1, 2, 0);
    pair(`ILS_CL_XRET, `ILS_CL_ALU, 1, 3, 1);
  endtask
  task rate_one;
    pair(`ILS_CL_STORE, `ILS_CL_STORE, 0, 1, 1);
    pair(`ILS_CL_FSTORE, `ILS_CL_FSTORE, 0, 1, 1);
    pair(`ILS_CL_LOAD, `ILS_CL_LOAD, 0, 1, 1);
    pair(`ILS_CL_MUL, `ILS_CL_MUL, 0, 1, 1);
    pair(`ILS_CL_FMA, `ILS_CL_FSUB, 0, 1, 1);
  endtask
  task var_lat;
    pair(`ILS_CL_REM, `ILS_CL_ALU, 1, 6, 0);
    pair(`ILS_CL_REM, `ILS_CL_ALU, 1, 24, 1);
    pair(`ILS_CL_REM, `ILS_CL_REM, 0, 3, 0);
    pair(`ILS_CL_FSQRTD, `ILS_CL_ALU, 1, 20, 0);
    pair(`ILS_CL_FSQRTD, `ILS_CL_FMA, 0, 3, 0);
    pair(`ILS_CL_FSQRTD, `ILS_CL_ALU, 1, 27, 1);
    sq_lat <= 5'h0E;
    pair(`ILS_CL_FSQRTS, `ILS_CL_ALU, 1, 12, 0);
    pair(`ILS_CL_FSQRTS, `ILS_CL_ALU, 1, 24, 1);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    fixed_lat;
    rate_one;
    var_lat;
    final_report;
  end
endmodule
